// file: logic/mvtc_regs.sv
// Purpose: mixer volume and tone control registers with gain decoding
// Assumes: classic wishbone slave, 32-bit data, one clock, sync reset
// Notes:   decoded gains are registered and follow a write by one cycle
//
// Notes on behaviour
// - upper byte is channel 2 mixer code
// - lower byte channel 1, same mapping
// - quarter dB per code from 0 dB
// - -46,-50,-60,-72 dB points, mute from E4
// - mode picks flat, minimum or maximum set
// - left treble 0..6 dB, flat gives 0
// - bass-select copies left treble to right
// - right treble uses the same mapping
// - left bass boost from mode set
// - right bass boost from mode set
// - bass 2 dB per code, caps 18/24
// - disable bit set turns resonant boost off
// - loading bit high while coefficient loads
// - bass boost only when bass-select is 0
//
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "mvtc_cfg.svh"
module mvtc_regs #(
    parameter int COEF_LOAD_CYC = `MVTC_COEF_LOAD_CYC
) (
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    input  wire logic                     wb_cyc_i,
    input  wire logic                     wb_stb_i,
    input  wire logic                     wb_we_i,
    input  wire logic [`MVTC_ADDR_W-1:0]  wb_adr_i,
    input  wire logic [3:0]               wb_sel_i,
    input  wire logic [31:0]              wb_dat_i,
    output logic      [31:0]              wb_dat_o,
    output logic                          wb_ack_o,
    output mvtc_pkg::mvtc_atten_t         mix_ch1_o,
    output mvtc_pkg::mvtc_atten_t         mix_ch2_o,
    output mvtc_pkg::mvtc_tone_t          tone_o,
    output logic                          resonant_load_o
);
    localparam logic [`MVTC_ADDR_W-1:0] ADR_MIXER =
        `MVTC_ADDR_W'(`MVTC_ADDR(`MVTC_IDX_MIXER_VOL));
    localparam logic [`MVTC_ADDR_W-1:0] ADR_TONE =
        `MVTC_ADDR_W'(`MVTC_ADDR(`MVTC_IDX_TONE_CTRL));
    localparam logic [`MVTC_ADDR_W-1:0] ADR_FEAT =
        `MVTC_ADDR_W'(`MVTC_ADDR(`MVTC_IDX_FEAT_CTRL));
    localparam logic [7:0] LOAD_CYC = 8'(COEF_LOAD_CYC);

    logic [15:0]           mixer_vol_q;
    logic [15:0]           tone_ctrl_q;
    logic                  bass_sel_q;
    logic [7:0]            load_cnt_q;
    logic                  ack_q;
    logic [31:0]           rdata_q;
    logic                  req;
    logic                  wr_stb;
    logic                  resonant_coef_loading;
    logic [7:0]            mixer_vol_ch1;
    logic [7:0]            mixer_vol_ch2;
    logic [1:0]            treble_left;
    logic [1:0]            treble_right;
    logic [3:0]            bass_boost_left;
    logic [3:0]            bass_boost_right;
    logic                  resonant_boost_disable;
    mvtc_pkg::mvtc_set_t   set_sel;
    mvtc_pkg::mvtc_tone_t  tone_d;
    mvtc_pkg::mvtc_atten_t mix_atten [2];

    // ---------------- wishbone slave ----------------
    // one wait state: ack one cycle after the request, dropped next cycle
    assign req    = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr_stb = req && wb_we_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req;
        end
    end
    assign wb_ack_o = ack_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mixer_vol_q <= `MVTC_RST_MIXER_VOL;
        end else if (wr_stb && wb_adr_i == ADR_MIXER) begin
            if (wb_sel_i[0]) begin
                mixer_vol_q[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                mixer_vol_q[15:8] <= wb_dat_i[15:8];
            end
        end
    end

    // loading bit is hardware status; software writes to it are dropped
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tone_ctrl_q <= `MVTC_RST_TONE_CTRL;
        end else if (wr_stb && wb_adr_i == ADR_TONE) begin
            if (wb_sel_i[0]) begin
                tone_ctrl_q[7:0] <= {wb_dat_i[7], 1'b0, wb_dat_i[5:0]};
            end
            if (wb_sel_i[1]) begin
                tone_ctrl_q[15:8] <= wb_dat_i[15:8];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bass_sel_q <= `MVTC_RST_FEAT_CTRL;
        end else if (wr_stb && wb_adr_i == ADR_FEAT && wb_sel_i[0]) begin
            bass_sel_q <= wb_dat_i[`MVTC_BASS_SEL_BIT];
        end
    end

    // unmapped addresses are acked, read zero and ignore writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_q <= '0;
        end else if (req && !wb_we_i) begin
            case (wb_adr_i)
                ADR_MIXER: begin
                    rdata_q <= {16'h0000, mixer_vol_q};
                end
                ADR_TONE: begin
                    rdata_q <= {16'h0000, tone_ctrl_q[15:7],
                                resonant_coef_loading, tone_ctrl_q[5:0]};
                end
                ADR_FEAT: begin
                    rdata_q <= {31'h00000000, bass_sel_q};
                end
                default: begin
                    rdata_q <= '0;
                end
            endcase
        end
    end
    assign wb_dat_o = rdata_q;

    // ---------------- field extraction ----------------
    assign mixer_vol_ch2 = mixer_vol_q[`MVTC_MIX2_MSB:`MVTC_MIX2_LSB];
    assign mixer_vol_ch1 = mixer_vol_q[`MVTC_MIX1_MSB:`MVTC_MIX1_LSB];
    assign treble_left      = tone_ctrl_q[`MVTC_TREB_L_MSB:`MVTC_TREB_L_LSB];
    assign treble_right     = tone_ctrl_q[`MVTC_TREB_R_MSB:`MVTC_TREB_R_LSB];
    assign bass_boost_left  = tone_ctrl_q[`MVTC_BASS_L_MSB:`MVTC_BASS_L_LSB];
    assign bass_boost_right = tone_ctrl_q[`MVTC_BASS_R_MSB:`MVTC_BASS_R_LSB];
    assign resonant_boost_disable = tone_ctrl_q[`MVTC_RES_OFF_BIT];

    // ---------------- mixer attenuation ----------------
    // both channels share one decoder design so the mapping cannot drift
    generate
        for (genvar ch = 0; ch < 2; ch++) begin : g_mix
            mvtc_atten_dec u_dec (
                .clk_i  (clk_i),
                .rst_i  (rst_i),
                .code_i (ch == 0 ? mixer_vol_ch1 : mixer_vol_ch2),
                .atten_o(mix_atten[ch])
            );
        end
    endgenerate
    assign mix_ch1_o = mix_atten[0];
    assign mix_ch2_o = mix_atten[1];

    // ---------------- tone decoding ----------------
    always_comb begin
        case (tone_ctrl_q[`MVTC_MODE_MSB:`MVTC_MODE_LSB])
            2'b00: begin
                set_sel = mvtc_pkg::MVTC_SET_FLAT;
            end
            2'b11: begin
                set_sel = mvtc_pkg::MVTC_SET_MAX;
            end
            default: begin
                set_sel = mvtc_pkg::MVTC_SET_MIN;
            end
        endcase
    end

    function automatic logic [4:0] treble_db(input mvtc_pkg::mvtc_set_t s,
                                             input logic [1:0] c);
        treble_db = (s == mvtc_pkg::MVTC_SET_FLAT) ? 5'h00 : {2'b00, c, 1'b0};
    endfunction : treble_db

    function automatic logic [4:0] bass_db(input mvtc_pkg::mvtc_set_t s,
                                           input logic [3:0] c);
        logic [4:0] raw;
        raw = {c, 1'b0};
        case (s)
            mvtc_pkg::MVTC_SET_MIN: begin
                bass_db = (raw > `MVTC_BASS_CAP_MIN) ? `MVTC_BASS_CAP_MIN : raw;
            end
            mvtc_pkg::MVTC_SET_MAX: begin
                bass_db = (raw > `MVTC_BASS_CAP_MAX) ? `MVTC_BASS_CAP_MAX : raw;
            end
            default: begin
                bass_db = 5'h00;
            end
        endcase
    endfunction : bass_db

    always_comb begin
        tone_d          = '0;
        tone_d.treble_l = treble_db(set_sel, treble_left);
        // bass-select makes the right channel follow the left treble
        tone_d.treble_r = treble_db(set_sel,
                                    bass_sel_q ? treble_left : treble_right);
        if (!bass_sel_q) begin
            tone_d.bass_l = bass_db(set_sel, bass_boost_left);
            tone_d.bass_r = bass_db(set_sel, bass_boost_right);
        end
        tone_d.resonant_en = !resonant_boost_disable;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tone_o <= '0;
        end else begin
            tone_o <= tone_d;
        end
    end

    // ---------------- resonant coefficient load ----------------
    // every tone control write with byte lane 0 or 1 selected reloads the coefficient; a new write
    // during a load restarts it so the filter never sees a stale value
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            load_cnt_q <= 8'h00;
        end else if (wr_stb && wb_adr_i == ADR_TONE && |wb_sel_i[1:0]) begin
            load_cnt_q <= LOAD_CYC;
        end else if (load_cnt_q != 8'h00) begin
            load_cnt_q <= load_cnt_q - 8'h01;
        end
    end
    assign resonant_coef_loading = (load_cnt_q != 8'h00);
    assign resonant_load_o       = resonant_coef_loading;

    // ---------------- checks ----------------
    wb_ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single pulse after request");

    ch2_upper_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (mixer_vol_q[15:8] == 8'h00)
            |=> mix_ch2_o.atten_qdb == 9'h000 && !mix_ch2_o.mute)
        else $error("channel 2 code zero not 0 dB");

    ch2_mute_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (mixer_vol_ch2 >= `MVTC_MUTE_CODE) |=> mix_ch2_o.mute)
        else $error("channel 2 mute code did not mute");

    seg_one_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (mixer_vol_ch2 == 8'hC0) |=> mix_ch2_o.atten_qdb == 9'h0C8)
        else $error("code C0 not -50 dB");

    ch1_lower_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (mixer_vol_ch1 < `MVTC_SEG1_CODE)
            |=> mix_ch1_o.atten_qdb == {1'b0, $past(mixer_vol_ch1)})
        else $error("channel 1 lower byte mapping wrong");

    quarter_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (mixer_vol_ch2 < `MVTC_SEG1_CODE)
            |=> mix_ch2_o.atten_qdb == {1'b0, $past(mixer_vol_ch2)} && !mix_ch2_o.mute)
        else $error("quarter dB step wrong");

    end_points_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (mixer_vol_ch1 == 8'hE0) |=> mix_ch1_o.atten_qdb == 9'h120 && !mix_ch1_o.mute)
        else $error("code E0 not -72 dB");

    mute_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (mixer_vol_ch1 >= `MVTC_MUTE_CODE) |=> mix_ch1_o.mute)
        else $error("mute code did not mute");

    mid_points_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (mixer_vol_ch2 == 8'hD4) |=> mix_ch2_o.atten_qdb == 9'h0F0)
        else $error("code D4 not -60 dB");

    interp_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (mixer_vol_ch1 == 8'hD8) |=> mix_ch1_o.atten_qdb == 9'h0FC)
        else $error("code D8 not -63 dB");

    flat_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (tone_ctrl_q[15:14] == 2'b00)
            |=> tone_o.treble_l == 5'h00 && tone_o.bass_l == 5'h00
                && tone_o.bass_r == 5'h00)
        else $error("flat set not flat");

    treble_map_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (tone_ctrl_q[15:14] != 2'b00)
            |=> tone_o.treble_l == {2'b00, $past(treble_left), 1'b0})
        else $error("left treble mapping wrong");

    treble_copy_a: assert property (@(posedge clk_i) disable iff (rst_i)
        bass_sel_q |=> tone_o.treble_r == tone_o.treble_l)
        else $error("right treble not following left");

    treble_right_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!bass_sel_q && tone_ctrl_q[15:14] != 2'b00)
            |=> tone_o.treble_r == {2'b00, $past(treble_right), 1'b0})
        else $error("right treble mapping wrong");

    bass_min_cap_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!bass_sel_q && tone_ctrl_q[15:14] == 2'b01 && bass_boost_left >= 4'h9)
            |=> tone_o.bass_l == 5'h12)
        else $error("minimum set bass cap wrong");

    mode_two_min_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!bass_sel_q && tone_ctrl_q[15:14] == 2'b10 && bass_boost_right >= 4'h9)
            |=> tone_o.bass_r == 5'h12)
        else $error("mode 10 not the minimum set");

    bass_max_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!bass_sel_q && tone_ctrl_q[15:14] == 2'b11 && bass_boost_left < 4'hC)
            |=> tone_o.bass_l == {$past(bass_boost_left), 1'b0})
        else $error("maximum set left bass wrong");

    bass_right_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!bass_sel_q && tone_ctrl_q[15:14] == 2'b11 && bass_boost_right >= 4'hC)
            |=> tone_o.bass_r == 5'h18)
        else $error("maximum set right bass cap wrong");

    bass_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
        bass_sel_q |=> tone_o.bass_l == 5'h00 && tone_o.bass_r == 5'h00)
        else $error("bass boost applied with bass-select set");

    resonant_en_a: assert property (@(posedge clk_i) disable iff (rst_i)
        1'b1 |=> tone_o.resonant_en == !$past(resonant_boost_disable))
        else $error("resonant enable not inverse of disable bit");

    coef_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_stb && wb_adr_i == ADR_TONE && wb_sel_i[0])
            |=> resonant_load_o [*4])
        else $error("loading bit not held after tone write");

    // a fresh write on the last count restarts the load instead
    load_done_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (load_cnt_q == 8'h01 && !(wr_stb && wb_adr_i == ADR_TONE))
            |=> !resonant_load_o)
        else $error("loading bit not cleared after load");

endmodule : mvtc_regs

// file: logic/mvtc_cfg.svh
// Purpose: offsets, field positions, reset values and counts for the
//          mixer volume and tone control register bank
// Assumes: 32-bit classic wishbone, byte address = 4 * register index
// Notes:   registers are addressed by index; byte addresses derive from it
`ifndef MVTC_CFG_SVH
`define MVTC_CFG_SVH

`define MVTC_IDX_MIXER_VOL   8'h11
`define MVTC_IDX_TONE_CTRL   8'h12
`define MVTC_IDX_FEAT_CTRL   8'h1F
`define MVTC_ADDR_W          8
`define MVTC_ADDR(idx)       ({(idx), 2'b00})

`define MVTC_RST_MIXER_VOL   16'hFF00
`define MVTC_RST_TONE_CTRL   16'h0000
`define MVTC_RST_FEAT_CTRL   1'b0

// mixer volume fields
`define MVTC_MIX2_MSB        15
`define MVTC_MIX2_LSB        8
`define MVTC_MIX1_MSB        7
`define MVTC_MIX1_LSB        0
// tone control fields
`define MVTC_MODE_MSB        15
`define MVTC_MODE_LSB        14
`define MVTC_TREB_L_MSB      13
`define MVTC_TREB_L_LSB      12
`define MVTC_BASS_L_MSB      11
`define MVTC_BASS_L_LSB      8
`define MVTC_RES_OFF_BIT     7
`define MVTC_RES_LOAD_BIT    6
`define MVTC_TREB_R_MSB      5
`define MVTC_TREB_R_LSB      4
`define MVTC_BASS_R_MSB      3
`define MVTC_BASS_R_LSB      0
// feature control field
`define MVTC_BASS_SEL_BIT    0

// attenuation breakpoints, codes and quarter-dB units
`define MVTC_SEG1_CODE       8'hB8
`define MVTC_SEG2_CODE       8'hD4
`define MVTC_SEG3_CODE       8'hDC
`define MVTC_MUTE_CODE       8'hE4
`define MVTC_SEG1_BASE       9'h0B8
`define MVTC_SEG2_BASE       9'h0F0
`define MVTC_SEG3_BASE       9'h108

// tone limits in dB
`define MVTC_BASS_CAP_MIN    5'h12
`define MVTC_BASS_CAP_MAX    5'h18

`define MVTC_COEF_LOAD_CYC   16

`endif

// file: logic/mvtc_pkg.sv
// Purpose: types shared by the mixer volume and tone control bank
// Assumes: nothing
// Notes:   gains in whole dB, attenuation in quarter-dB steps
package mvtc_pkg;

    typedef enum logic [1:0] {
        MVTC_SET_FLAT = 2'b00,
        MVTC_SET_MIN  = 2'b01,
        MVTC_SET_MAX  = 2'b11
    } mvtc_set_t;

    typedef struct packed {
        logic       mute;
        logic [8:0] atten_qdb;
    } mvtc_atten_t;

    typedef struct packed {
        logic [4:0] treble_l;
        logic [4:0] treble_r;
        logic [4:0] bass_l;
        logic [4:0] bass_r;
        logic       resonant_en;
    } mvtc_tone_t;

endpackage : mvtc_pkg

// file: logic/mvtc_atten_dec.sv
// Purpose: turn one mixer volume code into attenuation and mute
// Assumes: code is stable register content on clk_i
// Notes:   output registered, one cycle behind the code
`timescale 1ns/10ps
`include "mvtc_cfg.svh"
module mvtc_atten_dec (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic [7:0]           code_i,
    output mvtc_pkg::mvtc_atten_t     atten_o
);
    mvtc_pkg::mvtc_atten_t atten_d;
    logic [8:0]            off;

    always_comb begin
        off     = {1'b0, code_i};
        atten_d = '0;
        if (code_i >= `MVTC_MUTE_CODE) begin
            atten_d.mute      = 1'b1;
            atten_d.atten_qdb = 9'h1FF;
        end else if (code_i >= `MVTC_SEG3_CODE) begin
            // 1.5 dB per code; codes past -72 dB keep this slope
            off               = {1'b0, code_i - `MVTC_SEG3_CODE};
            atten_d.atten_qdb = 9'(`MVTC_SEG3_BASE + 6 * off);
        end else if (code_i >= `MVTC_SEG2_CODE) begin
            off               = {1'b0, code_i - `MVTC_SEG2_CODE};
            atten_d.atten_qdb = 9'(`MVTC_SEG2_BASE + 3 * off);
        end else if (code_i >= `MVTC_SEG1_CODE) begin
            // 0.5 dB per code, -46 dB at the segment start
            off               = {1'b0, code_i - `MVTC_SEG1_CODE};
            atten_d.atten_qdb = 9'(`MVTC_SEG1_BASE + 2 * off);
        end else begin
            atten_d.atten_qdb = {1'b0, code_i};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            atten_o <= '0;
        end else begin
            atten_o <= atten_d;
        end
    end

endmodule : mvtc_atten_dec

// file: test/test_mvtc_regs.sv
// Purpose: self-checking bench for the mixer volume and tone control bank
// Assumes: classic wishbone master tasks, ack one cycle after the taken edge
// Notes:   short coefficient load count keeps the loading window observable
`timescale 1ns/10ps
`include "mvtc_cfg.svh"
module test_mvtc_regs;
    localparam int          LOAD_CYC = 8;
    localparam logic [7:0]  A_MIX    = 8'(`MVTC_ADDR(`MVTC_IDX_MIXER_VOL));
    localparam logic [7:0]  A_TONE   = 8'(`MVTC_ADDR(`MVTC_IDX_TONE_CTRL));
    localparam logic [7:0]  A_FEAT   = 8'(`MVTC_ADDR(`MVTC_IDX_FEAT_CTRL));
    localparam logic [7:0]  A_NONE   = 8'h40;

    logic                   clk_i = 1'b0;
    logic                   rst_i = 1'b1;
    logic                   cyc   = 1'b0;
    logic                   stb   = 1'b0;
    logic                   we    = 1'b0;
    logic [7:0]             adr   = 8'h00;
    logic [3:0]             sel   = 4'h0;
    logic [31:0]            dat   = 32'h0000_0000;
    logic [31:0]            wb_dat_o;
    logic                   wb_ack_o;
    mvtc_pkg::mvtc_atten_t  mix_ch1_o;
    mvtc_pkg::mvtc_atten_t  mix_ch2_o;
    mvtc_pkg::mvtc_tone_t   tone_o;
    logic                   resonant_load_o;
    int                     mismatches = 0;
    int                     num_checks = 0;
    logic [31:0]            rd;
    logic [7:0]             codes [14] = '{8'h00, 8'h01, 8'hB7, 8'hB8, 8'hBC, 8'hC0, 8'hC1,
                                           8'hD4, 8'hD8, 8'hDC, 8'hE0, 8'hE3, 8'hE4, 8'hFF};

    always #12.5 clk_i = ~clk_i;

    mvtc_regs #(.COEF_LOAD_CYC(LOAD_CYC)) i_dut (
        .clk_i           (clk_i),
        .rst_i           (rst_i),
        .wb_cyc_i        (cyc),
        .wb_stb_i        (stb),
        .wb_we_i         (we),
        .wb_adr_i        (adr),
        .wb_sel_i        (sel),
        .wb_dat_i        (dat),
        .wb_dat_o        (wb_dat_o),
        .wb_ack_o        (wb_ack_o),
        .mix_ch1_o       (mix_ch1_o),
        .mix_ch2_o       (mix_ch2_o),
        .tone_o          (tone_o),
        .resonant_load_o (resonant_load_o)
    );

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test

    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk_word

    task automatic chk_flag(input string what, input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %b seen %b", what, exp, got);
        end
    endtask : chk_flag

    // one classic cycle; holds everything until ack is sampled high
    task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                           input logic [3:0] s, output logic [31:0] q);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        sel <= s;
        dat <= d;
        // no local limit: only the watchdog ends a hung wait
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb_xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] q;
        wb_xfer(1'b1, a, d, s, q);
    endtask : wr

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        wb_xfer(1'b0, a, 32'h0000_0000, 4'hF, rd);
        chk_word(what, exp, rd);
    endtask : rd_chk

    // decoded outputs follow the register by one more edge
    task automatic settle();
        repeat (2) @(posedge clk_i);
        #1;
    endtask : settle

    function automatic logic [8:0] exp_qdb(input logic [7:0] c);
        int v;
        v = int'(c);
        if (v > 8'hDC) v = 264 + 6 * (v - 8'hDC);
        else if (v > 8'hD4) v = 240 + 3 * (v - 8'hD4);
        else if (v > 8'hB8) v = 184 + 2 * (v - 8'hB8);
        return 9'(v);
    endfunction : exp_qdb

    task automatic chk_mix(input logic [7:0] c, input mvtc_pkg::mvtc_atten_t got);
        chk_flag("mute", c >= 8'hE4, got.mute);
        if (c < 8'hE4) chk_word("atten", 32'(exp_qdb(c)), 32'(got.atten_qdb));
    endtask : chk_mix

    task automatic chk_tone(input int tl, input int tr, input int bl, input int br);
        chk_word("treble_l", 32'(tl), 32'(tone_o.treble_l));
        chk_word("treble_r", 32'(tr), 32'(tone_o.treble_r));
        chk_word("bass_l", 32'(bl), 32'(tone_o.bass_l));
        chk_word("bass_r", 32'(br), 32'(tone_o.bass_r));
    endtask : chk_tone

    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        $display("unexpected watchdog expiry: expected end seen hang");
        end_of_test();
    end

    initial begin
        logic [1:0] m;
        logic [3:0] c;
        int         cap;
        int         bg;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk("mixer reset", A_MIX, 32'h0000_FF00);
        rd_chk("tone reset", A_TONE, 32'h0000_0000);
        rd_chk("feature reset", A_FEAT, 32'h0000_0000);
        chk_mix(8'h00, mix_ch1_o);
        chk_mix(8'hFF, mix_ch2_o);
        chk_flag("resonant_en", 1'b1, tone_o.resonant_en);
        $display("test reset done");

        for (int i = 0; i < 14; i++) begin
            wr(A_MIX, {16'h0000, codes[13 - i], codes[i]}, 4'h3);
            settle();
            chk_mix(codes[i], mix_ch1_o);
            chk_mix(codes[13 - i], mix_ch2_o);
        end
        wr(A_MIX, 32'hFFFF_55AB, 4'h1);
        wr(A_MIX, 32'h1234_0000, 4'hC);
        rd_chk("mixer lanes", A_MIX, 32'h0000_00AB);
        wr(A_NONE, 32'h0000_FFFF, 4'hF);
        rd_chk("unmapped", A_NONE, 32'h0000_0000);
        rd_chk("mixer kept", A_MIX, 32'h0000_00AB);
        $display("test mixer done");

        for (int mi = 0; mi < 4; mi++) begin
            for (int ci = 0; ci < 16; ci++) begin
                m = 2'(mi);
                c = 4'(ci);
                wr(A_TONE, {16'h0000, m, c[1:0], c, 2'b00, ~c[1:0], ~c}, 4'h3);
                settle();
                cap = (m == 2'b11) ? 24 : 18;
                bg = (m == 2'b00) ? 0 : 2;
                chk_tone(bg * (ci % 4), bg * (3 - ci % 4), (bg * ci > cap) ? cap : bg * ci,
                         (bg * (15 - ci) > cap) ? cap : bg * (15 - ci));
            end
        end
        $display("test tone done");

        repeat (LOAD_CYC + 4) @(posedge clk_i);
        wr(A_TONE, 32'h0000_00C0, 4'h3);
        rd_chk("tone loading", A_TONE, 32'h0000_00C0);
        #1;
        chk_flag("loading", 1'b1, resonant_load_o);
        chk_flag("resonant_en", 1'b0, tone_o.resonant_en);
        repeat (LOAD_CYC + 4) @(posedge clk_i);
        #1;
        chk_flag("loading", 1'b0, resonant_load_o);
        rd_chk("tone loaded", A_TONE, 32'h0000_0080);
        $display("test resonant done");

        wr(A_FEAT, 32'h0000_0001, 4'hF);
        wr(A_TONE, 32'h0000_F517, 4'h3);
        settle();
        chk_tone(6, 6, 0, 0);
        chk_flag("resonant_en", 1'b1, tone_o.resonant_en);
        rd_chk("feature", A_FEAT, 32'h0000_0001);
        wr(A_FEAT, 32'h0000_0000, 4'hF);
        settle();
        chk_tone(6, 2, 10, 14);
        $display("test bass select done");
        end_of_test();
    end
endmodule : test_mvtc_regs
